// *** logic/timer8_pkg.sv ***
package timer8_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_PIN = 8'h1C;

  // Field positions.
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WGM_HI_BIT = 3;
  localparam int CS_LSB = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_A = 1;
  localparam int FLAG_B = 2;
  localparam int PIN_PORT_A = 0;
  localparam int PIN_DIR_A = 1;
  localparam int PIN_PORT_B = 2;
  localparam int PIN_DIR_B = 3;
  localparam int PIN_ASYNC = 4;

  // Waveform mode select codes.
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMPA = 3'h5;
  localparam logic [2:0] WGM_FAST_CMPA = 3'h7;

  // Compare output mode codes.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam int PC_PERIOD_TICKS = 510;

  typedef enum logic {COUNT_UP, COUNT_DOWN} dir_e;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [1:0][1:0] com;
    logic [1:0] wgm_lo;
    logic wgm_hi;
    logic [2:0] cs;
    logic [7:0] cnt;
    dir_e dir;
    logic block;
    logic [9:0] presc;
    logic [1:0][7:0] ocr;
    logic [1:0][7:0] cmp_buf;
    logic [1:0] oc;
    logic [1:0] sym_fix;
    logic [2:0] flag;
    logic [2:0] irq_en;
    logic [1:0] port;
    logic [1:0] pdir;
    logic async_sel;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic osc_lvl;
    logic [1:0] pin;
    logic [1:0] pin_oe_n;
    logic [2:0] irq;
  } state_s;

  // Prescaler tap mask per clock select: 1, 8, 32, 64, 128, 256, 1024.
  function automatic logic [9:0] div_mask(input logic [2:0] cs);
    case (cs)
      3'h2: div_mask = 10'h007;
      3'h3: div_mask = 10'h01F;
      3'h4: div_mask = 10'h03F;
      3'h5: div_mask = 10'h07F;
      3'h6: div_mask = 10'h0FF;
      3'h7: div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction

endpackage

// *** logic/timer8_compare_waveform_unit.sv ***
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module timer8_compare_waveform_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_clk_i,
  input wire logic [2:0] irq_ack_i,
  output logic [2:0] irq_o,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_n_o
);

  timer8_pkg::state_s state_reg;
  timer8_pkg::state_s state_next;

  logic req;
  logic wr;
  logic [7:0] wdat;
  logic [2:0] wgm;
  logic pwm;
  logic pc;
  logic fast;
  logic [7:0] top;
  logic osc_rise;
  logic base_tick;
  logic [9:0] mask;
  logic tick;
  logic at_top;
  logic wrap;
  logic upd;
  logic turn_bot;
  logic ovf_ev;
  logic [1:0] match;
  logic [1:0] force_hit;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  function automatic logic nonpwm_action(input logic [1:0] com, input logic oc);
    case (com)
      timer8_pkg::COM_TOGGLE: nonpwm_action = ~oc;
      timer8_pkg::COM_CLEAR: nonpwm_action = 1'b0;
      timer8_pkg::COM_SET: nonpwm_action = 1'b1;
      default: nonpwm_action = oc;
    endcase
  endfunction

  // Dual-slope modes turn at top; every other mode wraps to bottom there.
  function automatic logic dual_slope(input logic [2:0] mode);
    dual_slope = (mode == timer8_pkg::WGM_PC_MAX) || (mode == timer8_pkg::WGM_PC_CMPA);
  endfunction

  function automatic logic fast_pwm(input logic [2:0] mode);
    fast_pwm = (mode == timer8_pkg::WGM_FAST_MAX) || (mode == timer8_pkg::WGM_FAST_CMPA);
  endfunction

  function automatic logic [7:0] cmp_offset(input int ch);
    cmp_offset = (ch == 0) ? timer8_pkg::OFS_CMP_A : timer8_pkg::OFS_CMP_B;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    wdat = wb_dat_i[7:0];
    wgm = {state_reg.wgm_hi, state_reg.wgm_lo};
    pc = dual_slope(wgm);
    fast = fast_pwm(wgm);
    pwm = pc | fast;
    if ((wgm == timer8_pkg::WGM_PC_CMPA) || (wgm == timer8_pkg::WGM_FAST_CMPA)
        || (wgm == timer8_pkg::WGM_CTC))
    begin
      top = state_reg.ocr[0];
    end
    else
    begin
      top = timer8_pkg::CNT_MAX;
    end

    // The oscillator is foreign to clk_i; only agreeing late stages are trusted.
    state_next.osc_s1 = osc_clk_i;
    state_next.osc_s2 = state_reg.osc_s1;
    state_next.osc_s3 = state_reg.osc_s2;
    if (state_reg.osc_s2 == state_reg.osc_s3)
    begin
      state_next.osc_lvl = state_reg.osc_s2;
    end
    osc_rise = (state_reg.osc_s2 == state_reg.osc_s3) & state_reg.osc_s2 & ~state_reg.osc_lvl;
    base_tick = state_reg.async_sel ? osc_rise : 1'b1;
    // The prescaler runs freely, so the first tick after a new clock select may come early.
    if (base_tick)
    begin
      state_next.presc = state_reg.presc + 10'h001;
    end
    mask = timer8_pkg::div_mask(state_reg.cs);
    tick = base_tick & (state_reg.cs != timer8_pkg::CS_STOP)
      & ((state_reg.presc & mask) == mask);

    at_top = state_reg.cnt == top;
    wrap = tick & ~pc & at_top;
    turn_bot = tick & pc & (state_reg.dir == timer8_pkg::COUNT_DOWN)
      & (state_reg.cnt == timer8_pkg::CNT_BOTTOM);
    ovf_ev = 1'b0;
    upd = 1'b0;
    if (tick)
    begin
      if (pc)
      begin
        // Up to top, down to bottom: 2 x 255 steps per period at full scale.
        if (state_reg.dir == timer8_pkg::COUNT_UP)
        begin
          if (at_top)
          begin
            state_next.dir = timer8_pkg::COUNT_DOWN;
            state_next.cnt = state_reg.cnt - timer8_pkg::CNT_ONE;
            upd = 1'b1;
          end
          else
          begin
            state_next.cnt = state_reg.cnt + timer8_pkg::CNT_ONE;
          end
        end
        else if (state_reg.cnt == timer8_pkg::CNT_BOTTOM)
        begin
          state_next.dir = timer8_pkg::COUNT_UP;
          state_next.cnt = state_reg.cnt + timer8_pkg::CNT_ONE;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - timer8_pkg::CNT_ONE;
          // Overflow is flagged as the count lands on bottom, not as it turns there.
          ovf_ev = state_reg.cnt == timer8_pkg::CNT_ONE;
        end
      end
      else
      begin
        state_next.dir = timer8_pkg::COUNT_UP;
        if (at_top)
        begin
          state_next.cnt = timer8_pkg::CNT_BOTTOM;
        end
        else
        begin
          state_next.cnt = state_reg.cnt + timer8_pkg::CNT_ONE;
        end
        ovf_ev = fast ? at_top : (state_reg.cnt == timer8_pkg::CNT_MAX);
        upd = fast & at_top;
      end
      state_next.block = 1'b0;
    end

    flag_set = {2'h0, ovf_ev};
    flag_clr = irq_ack_i;
    // Forcing is a non-PWM feature; in PWM modes a strobe write is dropped.
    force_hit = 2'h0;
    if (wr && (wb_adr_i == timer8_pkg::OFS_CTRL_B) && !pwm)
    begin
      force_hit = {wdat[timer8_pkg::FORCE_B_BIT], wdat[timer8_pkg::FORCE_A_BIT]};
    end

    for (int i = 0; i < 2; i++)
    begin
      // A match is seen on the tick that leaves the equal count, so its flag is set at the same edge as the count steps on.
      match[i] = tick & ~state_reg.block & (state_reg.cnt == state_reg.ocr[i]);
      flag_set[timer8_pkg::FLAG_A + i] = match[i];
      if (state_reg.com[i] != timer8_pkg::COM_OFF)
      begin
        if (pc && state_reg.com[i][1])
        begin
          if (match[i])
          begin
            if (state_reg.ocr[i] == timer8_pkg::CNT_MAX)
            begin
              state_next.oc[i] = ~state_reg.com[i][0];
            end
            else if (state_reg.ocr[i] == timer8_pkg::CNT_BOTTOM)
            begin
              state_next.oc[i] = state_reg.com[i][0];
            end
            else if (state_reg.dir == timer8_pkg::COUNT_UP)
            begin
              state_next.oc[i] = state_reg.com[i][0];
            end
            else
            begin
              state_next.oc[i] = ~state_reg.com[i][0];
            end
          end
          else if (turn_bot && state_reg.sym_fix[i])
          begin
            state_next.oc[i] = state_reg.com[i][0];
          end
        end
        else if (fast && state_reg.com[i][1])
        begin
          if (match[i])
          begin
            state_next.oc[i] = state_reg.com[i][0];
          end
          if (wrap)
          begin
            state_next.oc[i] = ~state_reg.com[i][0];
          end
        end
        else if (match[i] || force_hit[i])
        begin
          state_next.oc[i] = nonpwm_action(state_reg.com[i], state_reg.oc[i]);
        end
      end
      if (turn_bot)
      begin
        state_next.sym_fix[i] = 1'b0;
      end
      // Loading only at top keeps every pulse whole, and symmetric in the dual-slope modes.
      if (upd)
      begin
        state_next.ocr[i] = state_reg.cmp_buf[i];
        if ((state_reg.ocr[i] == timer8_pkg::CNT_MAX)
            && (state_reg.cmp_buf[i] != timer8_pkg::CNT_MAX))
        begin
          state_next.sym_fix[i] = 1'b1;
        end
      end
    end

    state_next.rdat = 8'h00;
    if (req)
    begin
      if (wb_adr_i == timer8_pkg::OFS_CTRL_A)
      begin
        state_next.rdat = {state_reg.com[0], state_reg.com[1], 2'b00, state_reg.wgm_lo};
        if (wr)
        begin
          // Mode bits take effect at once and never disturb the output register.
          state_next.com[0] = wdat[timer8_pkg::COM_A_LSB +: 2];
          state_next.com[1] = wdat[timer8_pkg::COM_B_LSB +: 2];
          state_next.wgm_lo = wdat[timer8_pkg::WGM_LO_LSB +: 2];
        end
      end
      else if (wb_adr_i == timer8_pkg::OFS_CTRL_B)
      begin
        state_next.rdat = {4'h0, state_reg.wgm_hi, state_reg.cs};
        if (wr)
        begin
          state_next.wgm_hi = wdat[timer8_pkg::WGM_HI_BIT];
          state_next.cs = wdat[timer8_pkg::CS_LSB +: 3];
        end
      end
      else if (wb_adr_i == timer8_pkg::OFS_COUNT)
      begin
        state_next.rdat = state_reg.cnt;
        if (wr)
        begin
          state_next.cnt = wdat;
          state_next.block = 1'b1;
          // A count above the compare value skips this period's up-count match.
          for (int i = 0; i < 2; i++)
          begin
            if (pc && (wdat > state_reg.ocr[i]))
            begin
              state_next.sym_fix[i] = 1'b1;
            end
          end
        end
      end
      else if ((wb_adr_i == timer8_pkg::OFS_CMP_A) || (wb_adr_i == timer8_pkg::OFS_CMP_B))
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (wb_adr_i == cmp_offset(i))
          begin
            state_next.rdat = pwm ? state_reg.cmp_buf[i] : state_reg.ocr[i];
            if (wr)
            begin
              state_next.cmp_buf[i] = wdat;
              if (!pwm)
              begin
                state_next.ocr[i] = wdat;
              end
            end
          end
        end
      end
      else if (wb_adr_i == timer8_pkg::OFS_FLAGS)
      begin
        state_next.rdat = {5'h00, state_reg.flag};
        if (wr)
        begin
          flag_clr = flag_clr | wdat[2:0];
        end
      end
      else if (wb_adr_i == timer8_pkg::OFS_IRQ_EN)
      begin
        state_next.rdat = {5'h00, state_reg.irq_en};
        if (wr)
        begin
          state_next.irq_en = wdat[2:0];
        end
      end
      else if (wb_adr_i == timer8_pkg::OFS_PIN)
      begin
        state_next.rdat = {3'h0, state_reg.async_sel, state_reg.pdir[1], state_reg.port[1],
          state_reg.pdir[0], state_reg.port[0]};
        if (wr)
        begin
          state_next.port = {wdat[timer8_pkg::PIN_PORT_B], wdat[timer8_pkg::PIN_PORT_A]};
          state_next.pdir = {wdat[timer8_pkg::PIN_DIR_B], wdat[timer8_pkg::PIN_DIR_A]};
          state_next.async_sel = wdat[timer8_pkg::PIN_ASYNC];
        end
      end
    end
    // Ack is a one-cycle pulse; a strobe held through it is taken again in the cycle after.
    state_next.ack = req;

    // A flag event in the same cycle as its clear is kept.
    state_next.flag = (state_reg.flag & ~flag_clr) | flag_set;
    state_next.irq = state_next.flag & state_next.irq_en;
    for (int i = 0; i < 2; i++)
    begin
      state_next.pin[i] = (state_next.com[i] != timer8_pkg::COM_OFF)
        ? state_next.oc[i] : state_next.port[i];
      state_next.pin_oe_n[i] = ~state_next.pdir[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      // Both pins are released in reset so that no level is forced onto the pads.
      state_reg.pin_oe_n <= '1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = {24'h00_0000, state_reg.rdat};
  assign irq_o = state_reg.irq;
  assign pin_o = state_reg.pin;
  assign pin_oe_n_o = state_reg.pin_oe_n;

endmodule

// *** tb/pin_pad_model.sv ***
`timescale 1ns/1ns
module pin_pad_model (
  input wire logic [1:0] pin_i,
  input wire logic [1:0] oe_n_i,
  output logic [1:0] pad_o
);
  // A released pad is pulled up, so it never keeps the last driven level.
  assign pad_o = (pin_i & ~oe_n_i) | oe_n_i;
endmodule

// *** tb/timer8_properties.sv ***
`timescale 1ns/1ns
module timer8_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] irq_o,
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe_n_o
);
  logic wr;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (wb_ack_o && wb_adr_i > timer8_pkg::OFS_PIN
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  AST_FORCE_ZERO: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == timer8_pkg::OFS_CTRL_B |-> wb_dat_o[7:6] == 2'h0)
    else $error("strobe bits read back set");
  AST_PIN_DIR: assert property (wr && wb_adr_i == timer8_pkg::OFS_PIN |=>
    pin_oe_n_o == ~{$past(wb_dat_i[3]), $past(wb_dat_i[1])}) else $error("enable wrong");
  AST_IRQ_MASK: assert property (wr && wb_adr_i == timer8_pkg::OFS_IRQ_EN |=>
    (irq_o & ~$past(wb_dat_i[2:0])) == 3'h0) else $error("masked request seen");
  AST_RESET_OUT: assert property ($fell(rst_i)
    |-> irq_o == 3'h0 && pin_o == 2'h0 && pin_oe_n_o == 2'h3 && !wb_ack_o)
    else $error("reset state wrong");
endmodule
bind timer8_compare_waveform_unit timer8_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o));

// *** tb/timer8_compare_waveform_unit_bench.sv ***
`timescale 1ns/1ns
module timer8_compare_waveform_unit_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] iack = 3'h0;
  logic osc = 1'b0;
  logic [2:0] irq;
  logic [1:0] pin;
  logic [1:0] oe_n;
  logic [1:0] pad;
  int num_errors = 0;
  int checks_done = 0;
  always #5 clk_i = ~clk_i;
  timer8_compare_waveform_unit dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .osc_clk_i(osc), .irq_ack_i(iack), .irq_o(irq), .pin_o(pin), .pin_oe_n_o(oe_n));
  pin_pad_model pad_u (.pin_i(pin), .oe_n_i(oe_n), .pad_o(pad));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up(input logic bad);
    if (bad)
    begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    give_up(n >= 20);
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(what, 16'(exp), 16'(q));
  endtask
  task automatic pad_chk(input string what, input logic exp);
    repeat (3) @(posedge clk_i);
    cmp(what, 16'(exp), 16'(pad[0]));
  endtask
  task automatic wait_irq(input int k);
    int n;
    for (n = 0; n < 600 && irq[k] !== 1'b1; n++)
      @(posedge clk_i);
    give_up(n >= 600);
  endtask
  // The first pass only finds a rising edge; a partial period would mislead.
  task automatic pwm_chk(input int ch, input int per_x, input int hi_x);
    logic p;
    logic c;
    int per;
    int hi;
    repeat (per_x + 90) @(posedge clk_i);
    for (int k = 0; k < 2; k++)
    begin
      p = 1'b1;
      c = 1'b1;
      per = 0;
      hi = 0;
      while (!(p === 1'b0 && c === 1'b1) && per < 9000)
      begin
        p = c;
        @(posedge clk_i);
        c = pad[ch];
        per++;
        hi += int'(c === 1'b1);
      end
      give_up(per >= 9000);
    end
    cmp("period", 16'(per_x), 16'(per));
    cmp("high", 16'(hi_x), 16'(hi));
  endtask
  task automatic steady(input logic lvl);
    int ones;
    ones = 0;
    // A new 0xFF reaches the output only after a copy at top and one more top; a new 0x00 by the bottom after the copy.
    repeat (1100) @(posedge clk_i);
    repeat (520)
    begin
      @(posedge clk_i);
      ones += int'(pad[0] === 1'b1);
    end
    cmp("steady", lvl ? 16'h0208 : 16'h0000, 16'(ones));
  endtask
  task automatic t_regs();
    rd_chk("ctrl_a", timer8_pkg::OFS_CTRL_A, 8'h00);
    rd_chk("flags", timer8_pkg::OFS_FLAGS, 8'h00);
    rd_chk("unmapped", 8'h40, 8'h00);
    wr(timer8_pkg::OFS_CTRL_B, 8'hC0);
    rd_chk("strobe", timer8_pkg::OFS_CTRL_B, 8'h00);
    wr(timer8_pkg::OFS_CMP_B, 8'h5A);
    rd_chk("active", timer8_pkg::OFS_CMP_B, 8'h5A);
  endtask
  task automatic t_force();
    logic [7:0] mode [4] = '{8'hC0, 8'h80, 8'h40, 8'h40};
    wr(timer8_pkg::OFS_PIN, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(timer8_pkg::OFS_CTRL_A, mode[i]);
      wr(timer8_pkg::OFS_CTRL_B, 8'h80);
      pad_chk("force", ~i[0]);
    end
    rd_chk("flags", timer8_pkg::OFS_FLAGS, 8'h00);
    rd_chk("count", timer8_pkg::OFS_COUNT, 8'h00);
    wr(timer8_pkg::OFS_CTRL_A, 8'hC0);
    wr(timer8_pkg::OFS_CTRL_B, 8'h80);
    wr(timer8_pkg::OFS_CTRL_A, 8'h00);
    pad_chk("port", 1'b0);
    wr(timer8_pkg::OFS_CTRL_B, 8'h80);
    wr(timer8_pkg::OFS_CTRL_A, 8'h41);
    pad_chk("kept", 1'b1);
    wr(timer8_pkg::OFS_CTRL_A, 8'h40);
    wr(timer8_pkg::OFS_CTRL_B, 8'h80);
    wr(timer8_pkg::OFS_PIN, 8'h00);
    pad_chk("released", 1'b1);
  endtask
  task automatic t_match();
    wr(timer8_pkg::OFS_CTRL_A, 8'h00);
    wr(timer8_pkg::OFS_CMP_A, 8'h05);
    wr(timer8_pkg::OFS_COUNT, 8'h05);
    wr(timer8_pkg::OFS_IRQ_EN, 8'h02);
    wr(timer8_pkg::OFS_CTRL_B, 8'h01);
    rd_chk("blocked", timer8_pkg::OFS_FLAGS, 8'h00);
    wait_irq(1);
    rd_chk("flags", timer8_pkg::OFS_FLAGS, 8'h07);
    wr(timer8_pkg::OFS_FLAGS, 8'h00);
    rd_chk("zero kept", timer8_pkg::OFS_FLAGS, 8'h07);
    wr(timer8_pkg::OFS_FLAGS, 8'h02);
    rd_chk("one clears", timer8_pkg::OFS_FLAGS, 8'h05);
    wait_irq(1);
    iack <= 3'h2;
    @(posedge clk_i);
    iack <= 3'h0;
    repeat (3) @(posedge clk_i);
    cmp("serviced", 16'h0000, 16'(irq[1]));
    wr(timer8_pkg::OFS_CTRL_B, 8'h00);
  endtask
  task automatic t_pwm();
    wr(timer8_pkg::OFS_COUNT, 8'h00);
    wr(timer8_pkg::OFS_PIN, 8'h0A);
    wr(timer8_pkg::OFS_CTRL_A, 8'h81);
    wr(timer8_pkg::OFS_CMP_A, 8'h40);
    rd_chk("buffer", timer8_pkg::OFS_CMP_A, 8'h40);
    wr(timer8_pkg::OFS_CTRL_B, 8'h01);
    pwm_chk(0, 510, 128);
    wr(timer8_pkg::OFS_CTRL_A, 8'hC1);
    pwm_chk(0, 510, 382);
    wr(timer8_pkg::OFS_CTRL_A, 8'h81);
    wr(timer8_pkg::OFS_FLAGS, 8'h07);
    wr(timer8_pkg::OFS_CMP_A, 8'h00);
    steady(1'b0);
    wr(timer8_pkg::OFS_CMP_A, 8'hFF);
    steady(1'b1);
    rd_chk("flags", timer8_pkg::OFS_FLAGS, 8'h07);
    wr(timer8_pkg::OFS_CMP_A, 8'h40);
    pwm_chk(0, 510, 128);
    wr(timer8_pkg::OFS_CTRL_B, 8'h00);
    wr(timer8_pkg::OFS_COUNT, 8'h01);
    wr(timer8_pkg::OFS_CTRL_A, 8'h21);
    wr(timer8_pkg::OFS_CMP_A, 8'h80);
    wr(timer8_pkg::OFS_CMP_B, 8'h20);
    wr(timer8_pkg::OFS_CTRL_B, 8'h09);
    pwm_chk(1, 256, 64);
    wr(timer8_pkg::OFS_CTRL_B, 8'h00);
    wr(timer8_pkg::OFS_CTRL_A, 8'h81);
    wr(timer8_pkg::OFS_CMP_A, 8'h40);
    wr(timer8_pkg::OFS_CTRL_B, 8'h02);
    pwm_chk(0, 4080, 1024);
  endtask
  task automatic t_async();
    wr(timer8_pkg::OFS_CTRL_B, 8'h00);
    wr(timer8_pkg::OFS_CTRL_A, 8'h00);
    wr(timer8_pkg::OFS_PIN, 8'h10);
    wr(timer8_pkg::OFS_COUNT, 8'h00);
    wr(timer8_pkg::OFS_CTRL_B, 8'h01);
    rd_chk("async idle", timer8_pkg::OFS_COUNT, 8'h00);
    repeat (20)
    begin
      repeat (4) @(posedge clk_i);
      osc <= ~osc;
    end
    repeat (8) @(posedge clk_i);
    rd_chk("async count", timer8_pkg::OFS_COUNT, 8'h0A);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_force();
    t_match();
    t_pwm();
    t_async();
    conclude();
  end
endmodule
